// ===== rtl/ibc_axis.sv
/*
  One axis of the correction datapath: adds a sign-extended trim to a sample
  and registers the result on the sample strobe.
  Assumes sample_valid is a one-cycle pulse on ref_clk.
*/
`timescale 1ns/1ns
`default_nettype none
module ibc_axis #(
  parameter int TRIM_BITS = 16
) (
  input  wire logic                 ref_clk,
  input  wire logic                 reset,
  input  wire logic                 sample_valid,
  input  wire logic signed [15:0]   sample_in,
  input  wire logic [15:0]          trim,
  output var  logic signed [15:0]   out_reg
);
  // ---------------------------------------------------------------
  // Sign extension and add
  // ---------------------------------------------------------------
  // Unused upper trim bits are ignored, not trusted
  logic signed [15:0] trim_ext;
  assign trim_ext = 16'(signed'(trim[TRIM_BITS-1:0]));

  // Offset added at the last step before loading; wraps like the sensor
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      out_reg <= 16'sh0000;
    end else if (sample_valid) begin
      out_reg <= sample_in + trim_ext;
    end
  end

  AST_AXIS_ADD: assert property (@(posedge ref_clk) disable iff (reset)
    sample_valid |=> out_reg == $past(sample_in) + $past(trim_ext))
    else $error("axis output is not sample plus trim");
endmodule // ibc_axis
`default_nettype wire

// ===== rtl/ibc_bias_core.sv
/*
  Bias correction core: six trim registers, misc, sample-period and range
  registers, auto bias command with a backup wait, and six corrected axes.
  Assumes byte frames arrive already deserialised and sampled on ref_clk.
*/
`timescale 1ns/1ns
`default_nettype none
module ibc_bias_core
  import ibc_pkg::*;
#(
  parameter int BACKUP_LEN = ibc_pkg::BACKUP_CYCLES
) (
  input  wire logic                        ref_clk,
  input  wire logic                        reset,
  input  wire logic                        frame_valid,
  input  wire logic [ibc_pkg::FRAME_W-1:0] frame_word,
  input  wire logic                        sample_valid,
  input  wire logic [95:0]                 raw_samples,
  output var  logic [95:0]                 corrected_out,
  output var  logic [15:0]                 read_data_reg,
  output var  logic                        backup_busy_reg,
  output var  logic                        backup_start_reg,
  output var  logic                        pop_enable_reg,
  output var  logic [ibc_pkg::DEC_W-1:0]   decimation_reg,
  output var  logic [ibc_pkg::RANGE_W-1:0] range_sel_reg
);
  typedef enum logic [1:0] {IBC_IDLE, IBC_LOAD, IBC_BACKUP} ibc_state_t;

  ibc_state_t  state_reg;
  logic [15:0] trim_reg [6];
  logic [15:0] misc_control_reg;
  logic [15:0] sample_period_reg;
  logic [15:0] range_filter_reg;
  logic [15:0] global_command_reg;
  logic [31:0] backup_cnt_reg;
  logic        wr;
  logic [6:0]  waddr;
  logic [7:0]  wdata;

  assign wr    = frame_valid && frame_word[FR_WR_BIT];
  assign waddr = frame_word[14:8];
  assign wdata = frame_word[7:0];

  // Word index of a trim register, or 7 when not a trim
  function automatic logic [2:0] trim_index(input logic [6:0] a);
    logic [6:0] even;
    even = {a[6:1], 1'b0};
    if (even >= ADDR_GYRO_X && even <= ADDR_ACCEL_Z) begin
      trim_index = 3'((even - ADDR_GYRO_X) >> 1);
    end else begin
      trim_index = 3'h7;
    end
  endfunction

  // ---------------------------------------------------------------
  // Trim registers, byte written; auto bias overrides gyro words
  // ---------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < 6; g++) begin : gen_trim
      logic [15:0] mask;
      assign mask = (g >= 4) ? ACC_YZ_MASK : 16'hffff;
      always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
          trim_reg[g] <= TRIM_RESET;
        end else if (g < 3 && state_reg == IBC_LOAD) begin
          // Negate the present gyro output at command start
          trim_reg[g] <= 16'(-corrected_out[16*g +: 16]);
        end else if (wr && trim_index(waddr) == 3'(g)) begin
          // Odd address carries the upper byte, sent first
          if (waddr[0]) begin
            trim_reg[g][15:8] <= wdata & mask[15:8];
          end else begin
            trim_reg[g][7:0] <= wdata;
          end
        end
      end
      ibc_axis #(.TRIM_BITS((g >= 4) ? ACC_YZ_W : TRIM_W)) u_axis (
        .ref_clk      (ref_clk),
        .reset        (reset),
        .sample_valid (sample_valid),
        .sample_in    (raw_samples[16*g +: 16]),
        .trim         (trim_reg[g]),
        .out_reg      (corrected_out[16*g +: 16])
      );
    end
  endgenerate

  // ---------------------------------------------------------------
  // Control registers, byte written
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      misc_control_reg  <= MISC_RESET;
      sample_period_reg <= SAMPLE_RESET;
      range_filter_reg  <= RANGE_RESET;
    end else if (wr) begin
      case (waddr)
        ADDR_MISC:         misc_control_reg[7:0]   <= wdata;
        ADDR_MISC + 7'h1:  misc_control_reg[15:8]  <= wdata;
        ADDR_SAMPLE:       sample_period_reg[7:0]  <= wdata;
        ADDR_SAMPLE + 7'h1: sample_period_reg[15:8] <= wdata;
        ADDR_RANGE:        range_filter_reg[7:0]   <= wdata;
        ADDR_RANGE + 7'h1: range_filter_reg[15:8]  <= wdata;
        default: ;
      endcase
    end
  end

  // Outputs derived from control fields, registered
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      pop_enable_reg <= 1'b0;
      decimation_reg <= '0;
      range_sel_reg  <= RANGE_1000;
    end else begin
      pop_enable_reg <= misc_control_reg[MISC_POP_BIT];
      decimation_reg <= sample_period_reg[DEC_LSB +: DEC_W];
      range_sel_reg  <= range_filter_reg[RANGE_LSB +: RANGE_W];
    end
  end

  // ---------------------------------------------------------------
  // Auto bias command sequence
  // ---------------------------------------------------------------
  // Backup wait keeps the command bit set so software can poll it
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      state_reg          <= IBC_IDLE;
      global_command_reg <= '0;
      backup_cnt_reg     <= '0;
      backup_busy_reg    <= 1'b0;
      backup_start_reg   <= 1'b0;
    end else begin
      backup_start_reg <= 1'b0;
      unique case (state_reg)
        IBC_IDLE: begin
          if (wr && waddr == ADDR_GLOBAL && wdata[CMD_AUTO_BIT]) begin
            global_command_reg[CMD_AUTO_BIT] <= 1'b1;
            state_reg       <= IBC_LOAD;
            backup_busy_reg <= 1'b1;
          end
        end
        IBC_LOAD: begin
          state_reg        <= IBC_BACKUP;
          backup_start_reg <= 1'b1;
          backup_cnt_reg   <= 32'(BACKUP_LEN);
        end
        IBC_BACKUP: begin
          if (backup_cnt_reg <= 32'h1) begin
            state_reg                        <= IBC_IDLE;
            backup_busy_reg                  <= 1'b0;
            global_command_reg[CMD_AUTO_BIT] <= 1'b0;
          end else begin
            backup_cnt_reg <= backup_cnt_reg - 32'h1;
          end
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Read port: word at the even address of a read frame
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      read_data_reg <= '0;
    end else if (frame_valid && !frame_word[FR_WR_BIT]) begin
      if (trim_index(waddr) != 3'h7) begin
        read_data_reg <= trim_reg[trim_index(waddr)];
      end else begin
        case ({waddr[6:1], 1'b0})
          ADDR_MISC:   read_data_reg <= misc_control_reg;
          ADDR_SAMPLE: read_data_reg <= sample_period_reg;
          ADDR_RANGE:  read_data_reg <= range_filter_reg;
          ADDR_GLOBAL: read_data_reg <= global_command_reg;
          default:     read_data_reg <= '0;
        endcase
      end
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  AST_AUTO_NEG: assert property (@(posedge ref_clk) disable iff (reset)
    state_reg == IBC_LOAD |=>
      trim_reg[0] == 16'(-$past(corrected_out[15:0])))
    else $error("gyro x trim is not the negated output");
  AST_BACKUP_AFTER: assert property (@(posedge ref_clk) disable iff (reset)
    state_reg == IBC_LOAD |=> backup_start_reg && backup_busy_reg)
    else $error("backup did not start after load");
  AST_CMD_HELD: assert property (@(posedge ref_clk) disable iff (reset)
    backup_busy_reg |-> global_command_reg[CMD_AUTO_BIT])
    else $error("command bit cleared during backup");
  AST_CMD_CLEAR: assert property (@(posedge ref_clk) disable iff (reset)
    $fell(backup_busy_reg) |-> !global_command_reg[CMD_AUTO_BIT])
    else $error("command bit not cleared after backup");
  AST_YZ_TOP: assert property (@(posedge ref_clk) disable iff (reset)
    trim_reg[4][15:14] == 2'b00 && trim_reg[5][15:14] == 2'b00)
    else $error("unused accel trim bits were set");
  AST_HI_BYTE: assert property (@(posedge ref_clk) disable iff (reset)
    (wr && waddr == 7'h1b && state_reg != IBC_LOAD) |=>
      trim_reg[0][15:8] == $past(wdata))
    else $error("upper byte not stored from odd address");
  AST_POP: assert property (@(posedge ref_clk) disable iff (reset)
    ##1 pop_enable_reg == $past(misc_control_reg[MISC_POP_BIT]))
    else $error("percussion enable does not follow bit 6");
  AST_RANGE: assert property (@(posedge ref_clk) disable iff (reset)
    ##1 range_sel_reg == $past(range_filter_reg[RANGE_LSB +: RANGE_W]))
    else $error("range select does not follow field");
  // Decimation output trails its register field by one cycle
  AST_DEC: assert property (@(posedge ref_clk) disable iff (reset)
    ##1 decimation_reg == $past(sample_period_reg[DEC_LSB +: DEC_W]))
    else $error("decimation does not follow field");
  // Y and Z gyro trims take the negated outputs too, not only X
  AST_AUTO_NEG_YZ: assert property (@(posedge ref_clk) disable iff (reset)
    state_reg == IBC_LOAD |=>
      trim_reg[1] == 16'(-$past(corrected_out[31:16])) &&
      trim_reg[2] == 16'(-$past(corrected_out[47:32])))
    else $error("gyro y or z trim is not the negated output");

  COV_AUTO: cover property (@(posedge ref_clk) $fell(backup_busy_reg));
  COV_WRITE: cover property (@(posedge ref_clk) wr && waddr == 7'h1b ##1
    wr && waddr == 7'h1a);
  COV_POP: cover property (@(posedge ref_clk) pop_enable_reg);
  COV_RANGE_250: cover property (@(posedge ref_clk) range_sel_reg == RANGE_250);
endmodule // ibc_bias_core
`default_nettype wire

// ===== rtl/ibc_pkg.sv
/*
  Package for the inertial bias correction block: register byte addresses,
  field positions, reset values and timing counts.
  Assumes a host that writes registers one byte per serial frame.
*/
package ibc_pkg;
  // ---------------------------------------------------------------
  // Register byte addresses (even byte of each word)
  // ---------------------------------------------------------------
  localparam logic [6:0] ADDR_GYRO_X   = 7'h1a;
  localparam logic [6:0] ADDR_GYRO_Y   = 7'h1c;
  localparam logic [6:0] ADDR_GYRO_Z   = 7'h1e;
  localparam logic [6:0] ADDR_ACCEL_X  = 7'h20;
  localparam logic [6:0] ADDR_ACCEL_Y  = 7'h22;
  localparam logic [6:0] ADDR_ACCEL_Z  = 7'h24;
  localparam logic [6:0] ADDR_MISC     = 7'h34;
  localparam logic [6:0] ADDR_SAMPLE   = 7'h36;
  localparam logic [6:0] ADDR_RANGE    = 7'h38;
  localparam logic [6:0] ADDR_GLOBAL   = 7'h3e;
  // ---------------------------------------------------------------
  // Fields and reset values
  // ---------------------------------------------------------------
  localparam int          TRIM_W          = 16;
  localparam int          ACC_YZ_W        = 14;
  localparam int          MISC_POP_BIT    = 6;
  localparam int          CMD_AUTO_BIT    = 0;
  localparam int          DEC_LSB         = 8;
  localparam int          DEC_W           = 5;
  localparam int          RANGE_LSB       = 8;
  localparam int          RANGE_W         = 3;
  localparam logic [15:0] TRIM_RESET      = 16'h0000;
  localparam logic [15:0] MISC_RESET      = 16'h0006;
  localparam logic [15:0] SAMPLE_RESET    = 16'h0001;
  localparam logic [15:0] RANGE_RESET     = 16'h0402;
  localparam logic [15:0] ACC_YZ_MASK     = 16'h3fff;
  localparam logic [2:0]  RANGE_1000      = 3'h4;
  localparam logic [2:0]  RANGE_500       = 3'h2;
  localparam logic [2:0]  RANGE_250       = 3'h1;
  // Frame layout: bit 15 write flag, 14:8 address, 7:0 data
  localparam int          FRAME_W         = 16;
  localparam int          FR_WR_BIT       = 15;
  // Backup time and its cycle count at 25 MHz
  localparam int          CLK_HZ          = 25_000_000;
  localparam int          BACKUP_US       = 100;
  localparam int          BACKUP_CYCLES   = BACKUP_US * (CLK_HZ / 1_000_000);
endpackage : ibc_pkg

// ===== verification/ibc_host_model.sv
/*
  Host model for the bias block: sends byte frames, reads words back and
  runs the auto bias command. Assumes one caller process and ref_clk.
*/
`timescale 1ns/1ns
`default_nettype none
module ibc_host_model (
  input  wire logic                        ref_clk,
  input  wire logic                        backup_busy_reg,
  input  wire logic [15:0]                 read_data_reg,
  output var  logic                        frame_valid,
  output var  logic [ibc_pkg::FRAME_W-1:0] frame_word
);
  import ibc_pkg::*;
  initial begin
    frame_valid = 1'b0;
    frame_word  = 16'h0000;
  end
  // One frame, taken at the second edge; word flips after, never held
  task automatic send(input logic [15:0] w);
    @(posedge ref_clk);
    frame_valid <= 1'b1;
    frame_word  <= w;
    @(posedge ref_clk);
    frame_valid <= 1'b0;
    frame_word  <= ~w;
  endtask
  // Upper byte to the odd address first, then the lower byte
  task automatic wr16(input logic [6:0] a, input logic [15:0] v);
    send({1'b1, a | 7'h01, v[15:8]});
    send({1'b1, a & 7'h7e, v[7:0]});
  endtask
  // Extra edge before sampling; the word stands until the next read
  task automatic rd16(input logic [6:0] a, output logic [15:0] v);
    send({1'b0, a, 8'h00});
    @(posedge ref_clk);
    #1 v = read_data_reg;
  endtask
  // Stay off the port until the backup ends, bounded
  task automatic auto_bias(output int waited);
    send({1'b1, ADDR_GLOBAL, 8'h01});
    waited = 0;
    @(posedge ref_clk);
    #1;
    while (backup_busy_reg === 1'b1 && waited < 1000) begin
      @(posedge ref_clk);
      #1 waited++;
    end
  endtask
endmodule // ibc_host_model
`default_nettype wire

// ===== verification/tb_inertial_bias_offset_correction.sv
/*
  Self-checking bench for the bias correction core with a host model.
  Assumes the core takes one frame or sample per strobe on ref_clk.
*/
`timescale 1ns/1ns
`default_nettype none
module tb_inertial_bias_offset_correction;
  import ibc_pkg::*;
  localparam int BL = 4;
  logic        ref_clk, reset, frame_valid, sample_valid;
  logic        backup_busy_reg, backup_start_reg, pop_enable_reg;
  logic [15:0] frame_word, read_data_reg;
  logic [95:0] raw_samples, corrected_out;
  logic [4:0]  decimation_reg;
  logic [2:0]  range_sel_reg;
  logic [15:0] wv [6];
  logic [15:0] et [6];
  int          fail_count, tests_run, starts;
  ibc_bias_core #(.BACKUP_LEN(BL)) ibc_bias_core_i (.ref_clk(ref_clk),
    .reset(reset), .frame_valid(frame_valid), .frame_word(frame_word),
    .sample_valid(sample_valid), .raw_samples(raw_samples),
    .corrected_out(corrected_out), .read_data_reg(read_data_reg),
    .backup_busy_reg(backup_busy_reg), .backup_start_reg(backup_start_reg),
    .pop_enable_reg(pop_enable_reg), .decimation_reg(decimation_reg),
    .range_sel_reg(range_sel_reg));
  ibc_host_model ibc_host_model_i (.ref_clk(ref_clk),
    .backup_busy_reg(backup_busy_reg), .read_data_reg(read_data_reg),
    .frame_valid(frame_valid), .frame_word(frame_word));
  // ----------------------------------------
  // Clock, pulse counter and helpers
  // ----------------------------------------
  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    if (backup_start_reg === 1'b1) starts++;
  end
  task automatic close_out();
    if (fail_count == 0 && tests_run > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    tests_run++;
    if (g !== e) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic chk_rd(input logic [6:0] a, input logic [15:0] e);
    logic [15:0] v;
    ibc_host_model_i.rd16(a, v);
    chk($sformatf("word at %h", a), e, v);
  endtask
  // Two edges: register first, control output one cycle later
  task automatic settle();
    repeat (2) @(posedge ref_clk);
    #1;
  endtask
  // Sample strobe, then check every axis against trim model
  task automatic put_sample(input logic [95:0] r);
    @(posedge ref_clk);
    sample_valid <= 1'b1;
    raw_samples  <= r;
    @(posedge ref_clk);
    sample_valid <= 1'b0;
    raw_samples  <= ~r;
    settle();
    for (int i = 0; i < 6; i++) begin
      chk("axis out", r[16*i+:16] + sx(et[i], i), corrected_out[16*i+:16]);
    end
  endtask
  function automatic logic [15:0] sx(input logic [15:0] t, input int i);
    return (i >= 4) ? {{2{t[13]}}, t[13:0]} : t;
  endfunction
  // Watchdog, far beyond the roughly 150 cycles of the run
  initial begin
    repeat (20000) @(posedge ref_clk);
    fail_count++;
    close_out();
  end
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    int w;
    reset = 1'b1;
    sample_valid = 1'b0;
    raw_samples = 96'h0;
    fail_count = 0;
    tests_run = 0;
    starts = 0;
    repeat (8) @(posedge ref_clk);
    reset <= 1'b0;
    for (int i = 0; i < 6; i++) chk_rd(7'(ADDR_GYRO_X + 2*i), TRIM_RESET);
    chk_rd(ADDR_MISC, MISC_RESET);
    chk_rd(ADDR_SAMPLE, SAMPLE_RESET);
    chk_rd(ADDR_RANGE, RANGE_RESET);
    chk_rd(7'h10, 16'h0000);
    chk("range sel", 16'h0004, {13'h0, range_sel_reg});
    // Gyro x trim: host negates a +10 LSB estimate
    wv = '{-16'sd10, 16'h0123, 16'h8000, 16'hfff4, 16'hc005, 16'he000};
    for (int i = 0; i < 6; i++) begin
      et[i] = (i >= 4) ? (wv[i] & ACC_YZ_MASK) : wv[i];
      ibc_host_model_i.wr16(7'(ADDR_GYRO_X + 2*i), wv[i]);
    end
    for (int i = 0; i < 6; i++) chk_rd(7'(ADDR_GYRO_X + 2*i), et[i]);
    // Gyro y wraps past the positive limit
    put_sample({16'h0000, 16'h0001, 16'h0010, 16'h1000, 16'h7f00, 16'h0100});
    ibc_host_model_i.wr16(ADDR_MISC, 16'h0046);
    settle();
    chk("percussion", 16'h0001, {15'h0, pop_enable_reg});
    ibc_host_model_i.send({1'b1, 7'h37, 8'h10});
    settle();
    chk("decimation", 16'h0010, {11'h0, decimation_reg});
    foreach (wv[i]) if (i < 3) begin
      ibc_host_model_i.send({1'b1, 7'h39, 5'h0, 3'(4 >> i)});
      settle();
      chk("range sel", 16'(4 >> i), {13'h0, range_sel_reg});
    end
    // Auto bias: gyro trims become the negated outputs
    put_sample({16'h0004, 16'h0003, 16'h0002, 16'hff00, 16'h0020, 16'h0040});
    et[0] = -(16'h0040 + et[0]);
    et[1] = -(16'h0020 + et[1]);
    et[2] = -(16'hff00 + et[2]);
    ibc_host_model_i.auto_bias(w);
    chk("backup wait", 16'h0001, {15'h0, w > 0 && w <= BL + 4});
    chk("backup starts", 16'h0001, 16'(starts));
    for (int i = 0; i < 6; i++) chk_rd(7'(ADDR_GYRO_X + 2*i), et[i]);
    chk_rd(ADDR_GLOBAL, 16'h0000);
    put_sample({16'h0004, 16'h0003, 16'h0002, 16'hff00, 16'h0020, 16'h0040});
    // Reset in mid-run clears the trims again
    @(posedge ref_clk);
    reset <= 1'b1;
    repeat (2) @(posedge ref_clk);
    reset <= 1'b0;
    chk_rd(ADDR_GYRO_X, TRIM_RESET);
    chk("pop after reset", 16'h0000, {15'h0, pop_enable_reg});
    chk("range after reset", 16'h0004, {13'h0, range_sel_reg});
    chk_rd(ADDR_GLOBAL, 16'h0000);
    close_out();
  end
endmodule // tb_inertial_bias_offset_correction
`default_nettype wire
